// *** lcdid_defs.svh ***
`ifndef LCDID_DEFS_SVH
`define LCDID_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LCDID_CLK_MHZ          200
`define LCDID_INIT_TIME_NS     1000
`define LCDID_INIT_CYCLES      ((`LCDID_INIT_TIME_NS * `LCDID_CLK_MHZ + 999) / 1000)
`define LCDID_LINE_DIV         4

// ----------------------------------------------------------------
// Panel geometry and column pointer limits
// ----------------------------------------------------------------
`define LCDID_COLS             96
`define LCDID_PAGES            8
`define LCDID_LINES            58
`define LCDID_COL_STOP         7'h60

// ----------------------------------------------------------------
// Instruction opcodes and field positions
// ----------------------------------------------------------------
`define LCDID_OP7_DISP_ONOFF   7'h57
`define LCDID_OP7_SEG_DIR      7'h50
`define LCDID_OP7_INVERSE      7'h53
`define LCDID_OP7_WHOLE_ON     7'h52
`define LCDID_OP7_INT_POWER    7'h12
`define LCDID_OP5_COL_HIGH     5'h02
`define LCDID_OP4_COL_LOW      4'h0
`define LCDID_OP4_PAGE         4'hb
`define LCDID_OP4_CONTRAST     4'h8
`define LCDID_OP4_SCAN_ORDER   4'hc
`define LCDID_OP_RMW           8'he0
`define LCDID_OP_END           8'hee
`define LCDID_OP_RESET         8'he2
`define LCDID_OP_DRIVE_SET     8'hed
`define LCDID_SCAN_ORDER_POS   3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LCDID_RST_COL          7'h00
`define LCDID_RST_PAGE         3'h0
`define LCDID_RST_CONTRAST     4'h0

`endif

// *** lcdid_pkg.sv ***
package lcdid_pkg;

  // Host access as presented on the bus
  typedef struct packed {
    logic       data_sel;   // 1: display data, 0: instruction/status
    logic       write;      // 1: write, 0: read
    logic [7:0] wdata;
  } lcdid_access_t;

  typedef struct packed {
    logic       busy;
    logic       dir_normal;
    logic       disp_off;
    logic       init;
    logic [3:0] zero;
  } lcdid_status_t;

  typedef enum logic [2:0] {
    LCDID_ST_IDLE = 3'b001,
    LCDID_ST_EXEC = 3'b010,
    LCDID_ST_PUSH = 3'b100
  } lcdid_state_t;

endpackage

// *** lcdid_pair_buf.sv ***
`timescale 1ns/10ps
`default_nettype none

module lcdid_pair_buf #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clock,     // System clock
  input  wire logic             i_srst,      // Synchronous reset
  input  wire logic             i_clock_en,  // Freezes state when low
  input  wire logic             i_in_valid,  // Producer has a word
  output logic                  o_in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] i_in_data,   // Word in
  output logic                  o_out_valid, // Word available
  input  wire logic             i_out_ready, // Consumer takes word
  output logic [WIDTH-1:0]      o_out_data   // Word out
);

  logic             skid_valid_reg;
  logic [WIDTH-1:0] skid_data_reg;
  logic             push;
  logic             pop;

  // Ready comes from a flop so the producer never sees a combinational path
  assign o_in_ready = ~skid_valid_reg;
  assign push       = i_in_valid & ~skid_valid_reg;
  assign pop        = o_out_valid & i_out_ready;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_out_valid    <= 1'b0;
      o_out_data     <= '0;
      skid_valid_reg <= 1'b0;
      skid_data_reg  <= '0;
    end else if (i_clock_en) begin
      if (pop || !o_out_valid) begin
        if (skid_valid_reg) begin
          o_out_valid    <= 1'b1;
          o_out_data     <= skid_data_reg;
          skid_valid_reg <= 1'b0;
        end else begin
          o_out_valid <= push;
          if (push) begin
            o_out_data <= i_in_data;
          end
        end
      end else if (push) begin
        skid_valid_reg <= 1'b1;
        skid_data_reg  <= i_in_data;
      end
    end
  end

endmodule

`default_nettype wire

// *** lcdid_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "lcdid_defs.svh"

module lcdid_decoder
  import lcdid_pkg::*;
#(
  parameter int INIT_CYCLES = `LCDID_INIT_CYCLES,
  parameter int LINE_DIV    = `LCDID_LINE_DIV
) (
  input  wire logic                   i_clock,                  // 200 MHz clock
  input  wire logic                   i_srst,                   // Hardware reset pin, sync
  input  wire logic                   i_clock_en,               // Freezes all state when low
  input  wire logic                   i_access_valid,           // Host access offered
  input  wire lcdid_access_t          i_access,                 // Select, direction, byte
  output logic                        o_access_ready,           // Access taken this cycle
  output logic                        o_rd_valid,               // Read byte available
  input  wire logic                   i_rd_ready,               // Host takes read byte
  output logic [7:0]                  o_rd_data,                // Status or display byte
  output logic [`LCDID_COLS-1:0]      o_segment_driver_outputs, // Lit pattern per segment
  output logic [`LCDID_LINES-1:0]     o_common_outputs,         // Active common line
  output logic                        o_outputs_at_supply,      // All drivers at supply
  output logic [3:0]                  o_lcd_drive_level,        // Contrast step
  output logic                        o_scan_order_bit,         // Common scan order
  output logic                        o_int_power_on,           // Internal supply enable
  output logic                        o_osc_run                 // Oscillator running
);

  localparam int COLS   = `LCDID_COLS;
  localparam int DEPTH  = `LCDID_PAGES * `LCDID_COLS;
  localparam int CNT_W  = 16;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lcdid_state_t   state_reg;
  lcdid_access_t  acc_reg;
  logic [7:0]     mem [0:DEPTH-1];
  logic [6:0]     col_reg;
  logic [6:0]     col_saved_reg;
  logic [2:0]     page_reg;
  logic           rmw_reg;
  logic           disp_on_reg;
  logic           seg_rev_reg;
  logic           inverse_reg;
  logic           whole_on_reg;
  logic           drive_en_reg;
  logic           psave_reg;
  logic [3:0]     contrast_register;
  logic           scan_order_reg;
  logic           int_power_reg;
  logic [CNT_W-1:0] init_cnt_reg;
  logic [7:0]     rd_latch_reg;
  logic [7:0]     push_data_reg;
  logic [5:0]     line_reg;
  logic [7:0]     div_reg;

  logic           acc_fire;
  logic           init_active;
  logic           exec_cmd;
  logic           exec_wdata;
  logic           exec_rdata;
  logic           exec_status;
  logic [7:0]     cmd;
  logic [9:0]     cur_addr;
  logic           col_valid;
  logic           buf_in_ready;
  logic           is_reset_cmd;
  lcdid_status_t  status;

  assign init_active = (init_cnt_reg != '0);
  assign acc_fire    = i_access_valid & o_access_ready;
  assign cmd         = acc_reg.wdata;
  assign exec_cmd    = (state_reg == LCDID_ST_EXEC) & ~acc_reg.data_sel & acc_reg.write;
  assign exec_wdata  = (state_reg == LCDID_ST_EXEC) & acc_reg.data_sel & acc_reg.write;
  assign exec_rdata  = (state_reg == LCDID_ST_EXEC) & acc_reg.data_sel & ~acc_reg.write;
  assign exec_status = (state_reg == LCDID_ST_EXEC) & ~acc_reg.data_sel & ~acc_reg.write;
  assign is_reset_cmd = exec_cmd & (cmd == `LCDID_OP_RESET);
  assign col_valid   = (col_reg < `LCDID_COL_STOP);
  assign cur_addr    = 10'(page_reg) * 10'(COLS) + 10'(col_reg);

  // Busy reflects the initialization period only: a status read is taken while idle
  assign status.busy       = init_active;
  assign status.dir_normal = ~seg_rev_reg;
  assign status.disp_off   = ~disp_on_reg;
  assign status.init       = init_active;
  assign status.zero       = 4'h0;

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  // During initialization only status reads are taken; anything else is dropped.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg      <= LCDID_ST_IDLE;
      acc_reg        <= '0;
      o_access_ready <= 1'b1;
    end else if (i_clock_en) begin
      case (state_reg)
        LCDID_ST_IDLE: begin
          if (acc_fire) begin
            o_access_ready <= 1'b0;
            if (!init_active || (!i_access.data_sel && !i_access.write)) begin
              acc_reg   <= i_access;
              state_reg <= LCDID_ST_EXEC;
            end else begin
              o_access_ready <= 1'b1;
            end
          end
        end
        LCDID_ST_EXEC: begin
          if (!acc_reg.write) begin
            state_reg <= LCDID_ST_PUSH;
          end else begin
            state_reg      <= LCDID_ST_IDLE;
            o_access_ready <= 1'b1;
          end
        end
        LCDID_ST_PUSH: begin
          // Stall here while the host leaves both buffer slots full
          if (buf_in_ready) begin
            state_reg      <= LCDID_ST_IDLE;
            o_access_ready <= 1'b1;
          end
        end
        default: begin
          state_reg      <= LCDID_ST_IDLE;
          o_access_ready <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Initialization period
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      init_cnt_reg <= CNT_W'(INIT_CYCLES);
    end else if (i_clock_en) begin
      if (is_reset_cmd) begin
        init_cnt_reg <= CNT_W'(INIT_CYCLES);
      end else if (init_active) begin
        init_cnt_reg <= init_cnt_reg - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Column and page pointers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      col_reg       <= `LCDID_RST_COL;
      col_saved_reg <= `LCDID_RST_COL;
      page_reg      <= `LCDID_RST_PAGE;
      rmw_reg       <= 1'b0;
    end else if (i_clock_en) begin
      if (is_reset_cmd) begin
        col_reg  <= `LCDID_RST_COL;
        page_reg <= `LCDID_RST_PAGE;
        rmw_reg  <= 1'b0;
      end else if (exec_cmd) begin
        if (cmd[7:4] == `LCDID_OP4_PAGE) begin
          page_reg <= cmd[2:0];
        end else if (cmd[7:3] == `LCDID_OP5_COL_HIGH) begin
          col_reg[6:4] <= cmd[2:0];
        end else if (cmd[7:4] == `LCDID_OP4_COL_LOW) begin
          col_reg[3:0] <= cmd[3:0];
        end else if (cmd == `LCDID_OP_RMW) begin
          rmw_reg       <= 1'b1;
          col_saved_reg <= col_reg;
        end else if (cmd == `LCDID_OP_END && rmw_reg) begin
          rmw_reg <= 1'b0;
          col_reg <= col_saved_reg;
        end
      end else if ((exec_wdata || (exec_rdata && !rmw_reg)) && col_valid) begin
        // Page stays put; the pointer parks at the stop value
        col_reg <= col_reg + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Display memory and read path
  // ----------------------------------------------------------------
  // Memory is never cleared by either reset.
  always_ff @(posedge i_clock) begin
    if (i_clock_en && exec_wdata && col_valid) begin
      mem[cur_addr] <= cmd;
    end
  end

  // A read hands out the latched byte and refills the latch from the pointer,
  // hence the discarded first read after moving the column pointer.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rd_latch_reg  <= 8'h00;
      push_data_reg <= 8'h00;
    end else if (i_clock_en) begin
      if (exec_rdata) begin
        push_data_reg <= rd_latch_reg;
        rd_latch_reg  <= col_valid ? mem[cur_addr] : 8'h00;
      end else if (exec_status) begin
        push_data_reg <= status;
      end
    end
  end

  lcdid_pair_buf #(
    .WIDTH (8)
  ) u_rd_buf (
    .i_clock     (i_clock),
    .i_srst      (i_srst),
    .i_clock_en  (i_clock_en),
    .i_in_valid  (state_reg == LCDID_ST_PUSH),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (push_data_reg),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data)
  );

  // ----------------------------------------------------------------
  // Display mode and power controls
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      disp_on_reg    <= 1'b0;
      seg_rev_reg    <= 1'b0;
      inverse_reg    <= 1'b0;
      whole_on_reg   <= 1'b0;
      int_power_reg  <= 1'b0;
      drive_en_reg   <= 1'b0;
    end else if (i_clock_en && exec_cmd) begin
      if (cmd[7:1] == `LCDID_OP7_DISP_ONOFF) begin
        disp_on_reg <= cmd[0];
      end else if (cmd[7:1] == `LCDID_OP7_SEG_DIR) begin
        seg_rev_reg <= cmd[0];
      end else if (cmd[7:1] == `LCDID_OP7_INVERSE) begin
        inverse_reg <= cmd[0];
      end else if (cmd[7:1] == `LCDID_OP7_WHOLE_ON) begin
        whole_on_reg <= cmd[0];
      end else if (cmd[7:1] == `LCDID_OP7_INT_POWER) begin
        int_power_reg <= cmd[0];
      end else if (cmd == `LCDID_OP_DRIVE_SET) begin
        drive_en_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      contrast_register <= `LCDID_RST_CONTRAST;
      scan_order_reg    <= 1'b0;
    end else if (i_clock_en) begin
      if (is_reset_cmd) begin
        contrast_register <= `LCDID_RST_CONTRAST;
        scan_order_reg    <= 1'b0;
      end else if (exec_cmd && cmd[7:4] == `LCDID_OP4_CONTRAST) begin
        contrast_register <= cmd[3:0];
      end else if (exec_cmd && cmd[7:4] == `LCDID_OP4_SCAN_ORDER) begin
        scan_order_reg <= cmd[`LCDID_SCAN_ORDER_POS];
      end
    end
  end

  // Power save follows the mode bits; modes and memory are kept across it
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      psave_reg           <= 1'b0;
      o_outputs_at_supply <= 1'b1;
      o_osc_run           <= 1'b1;
      o_int_power_on      <= 1'b0;
      o_lcd_drive_level   <= `LCDID_RST_CONTRAST;
      o_scan_order_bit    <= 1'b0;
    end else if (i_clock_en) begin
      psave_reg           <= ~disp_on_reg & whole_on_reg;
      o_outputs_at_supply <= ~drive_en_reg | psave_reg;
      o_osc_run           <= ~psave_reg;
      o_int_power_on      <= int_power_reg & ~psave_reg;
      o_lcd_drive_level   <= contrast_register;
      o_scan_order_bit    <= scan_order_reg;
    end
  end

  // ----------------------------------------------------------------
  // Line scan
  // ----------------------------------------------------------------
  // Scan halts with the oscillator in power save.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      div_reg  <= 8'h00;
      line_reg <= 6'h00;
    end else if (i_clock_en && !psave_reg) begin
      if (div_reg == 8'(LINE_DIV - 1)) begin
        div_reg  <= 8'h00;
        line_reg <= (line_reg == 6'(`LCDID_LINES - 1)) ? 6'h00 : line_reg + 6'h01;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_common_outputs <= '0;
    end else if (i_clock_en) begin
      o_common_outputs <= (disp_on_reg && !psave_reg) ? (`LCDID_LINES'(1) << line_reg) : '0;
    end
  end

  // ----------------------------------------------------------------
  // Segment data
  // ----------------------------------------------------------------
  logic [9:0] line_base;
  assign line_base = 10'(line_reg[5:3]) * 10'(COLS);

  genvar g;
  generate
    for (g = 0; g < COLS; g = g + 1) begin : g_seg
      logic [6:0] src_col;
      logic       ram_bit;
      assign src_col = seg_rev_reg ? 7'(COLS - 1 - g) : 7'(g);
      assign ram_bit = mem[line_base + 10'(src_col)][line_reg[2:0]];
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          o_segment_driver_outputs[g] <= 1'b0;
        end else if (i_clock_en) begin
          if (!disp_on_reg || psave_reg) begin
            o_segment_driver_outputs[g] <= 1'b0;
          end else if (whole_on_reg) begin
            o_segment_driver_outputs[g] <= 1'b1;
          end else begin
            o_segment_driver_outputs[g] <= ram_bit ^ inverse_reg;
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// *** lcdid_decoder_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lcdid_defs.svh"
module lcdid_decoder_chk
  import lcdid_pkg::*;
#(
  parameter int INIT_CYCLES = 200,
  parameter int LINE_DIV    = 4
) (
  input wire logic                    i_clock,                  // Clock
  input wire logic                    i_srst,                   // Reset
  input wire logic                    i_clock_en,               // Run
  input wire logic                    i_access_valid,           // Offer
  input wire lcdid_access_t           i_access,                 // Access
  input wire logic                    o_access_ready,           // Take
  input wire logic                    o_rd_valid,               // Byte ready
  input wire logic                    i_rd_ready,               // Byte pulled
  input wire logic [7:0]              o_rd_data,                // Byte
  input wire logic [`LCDID_COLS-1:0]  o_segment_driver_outputs, // Segments
  input wire logic [`LCDID_LINES-1:0] o_common_outputs,         // Commons
  input wire logic                    o_outputs_at_supply,      // At supply
  input wire logic [3:0]              o_lcd_drive_level,        // Contrast
  input wire logic                    o_scan_order_bit,         // Scan order
  input wire logic                    o_int_power_on,           // Supply on
  input wire logic                    o_osc_run                 // Oscillator
);
  // ----
  // Helper state
  // ----
  logic       take;
  logic       cmd;
  logic       is_status_reg;
  logic       disp_on_reg;
  logic [3:0] level_reg;
  assign take = i_access_valid & o_access_ready & i_clock_en;
  assign cmd  = take & i_access.write & ~i_access.data_sel;
  // Reads are strictly sequential on the bench, so one flag tags the byte
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      is_status_reg <= 1'b0;
    end else if (take && !i_access.write) begin
      is_status_reg <= !i_access.data_sel;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      disp_on_reg <= 1'b0;
    end else if (cmd && i_access.wdata[7:1] == 7'h57) begin
      disp_on_reg <= i_access.wdata[0];
    end
  end
  always_ff @(posedge i_clock) begin
    if (cmd && i_access.wdata[7:4] == 4'h8) begin
      level_reg <= i_access.wdata[3:0];
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // ----
  // Assertions
  // ----
  AST_WR_DONE: assert property (take && i_access.write |=> !o_access_ready ##1 o_access_ready)
    else $error("write handshake timing wrong");
  AST_RD_STATUS: assert property (take && !i_access.write && !i_access.data_sel && !o_rd_valid
    |-> ##[3:4] o_rd_valid)
    else $error("status read not answered");
  AST_STATUS_ZERO: assert property (o_rd_valid && is_status_reg |-> o_rd_data[3:0] == 4'h0)
    else $error("status low nibble not zero");
  AST_BUSY_INIT: assert property (o_rd_valid && is_status_reg |-> o_rd_data[7] == o_rd_data[4])
    else $error("busy and init flags disagree");
  AST_RD_HOLD: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data))
    else $error("read byte lost while stalled");
  AST_SAVE: assert property (!o_osc_run |-> !o_int_power_on && o_outputs_at_supply)
    else $error("power save outputs wrong");
  AST_DARK: assert property (!disp_on_reg && $past(disp_on_reg, 3) == 1'b0 |-> o_common_outputs == '0)
    else $error("commons active with display off");
  AST_CONTRAST: assert property (cmd && i_access.wdata[7:4] == 4'h8 |-> ##3 o_lcd_drive_level == level_reg)
    else $error("contrast not loaded");
  AST_RESET_CMD: assert property (cmd && i_access.wdata == 8'he2
    |-> ##3 o_lcd_drive_level == 4'h0 && !o_scan_order_bit)
    else $error("reset instruction did not clear");
  COV_DATA: cover property (take && i_access.data_sel && !i_access.write);
  COV_SAVE: cover property (!o_osc_run);
  COV_STALL: cover property (o_rd_valid && !i_rd_ready);
endmodule
bind lcdid_decoder lcdid_decoder_chk #(.INIT_CYCLES(INIT_CYCLES), .LINE_DIV(LINE_DIV)) chk_u (
  .i_clock(i_clock), .i_srst(i_srst), .i_clock_en(i_clock_en), .i_access_valid(i_access_valid),
  .i_access(i_access), .o_access_ready(o_access_ready), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready),
  .o_rd_data(o_rd_data), .o_segment_driver_outputs(o_segment_driver_outputs),
  .o_common_outputs(o_common_outputs), .o_outputs_at_supply(o_outputs_at_supply),
  .o_lcd_drive_level(o_lcd_drive_level), .o_scan_order_bit(o_scan_order_bit),
  .o_int_power_on(o_int_power_on), .o_osc_run(o_osc_run)
);
`default_nettype wire

// *** lcdid_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module lcdid_host_model
  import lcdid_pkg::*;
(
  input  wire logic         i_clock,        // Bench clock
  input  wire logic         i_access_ready, // Access taken
  input  wire logic         i_rd_valid,     // Byte waiting
  input  wire logic [7:0]   i_rd_data,      // Byte
  output var logic          o_access_valid, // Access offered
  output var lcdid_access_t o_access,       // Select, direction, byte
  output var logic          o_rd_ready      // Byte pulled
);
  int lag  = 0;
  int errs = 0;
  initial begin
    o_access_valid = 1'b0;
    o_access       = '0;
    o_rd_ready     = 1'b0;
  end
  // Inputs move at falling edges only, so the device never sees a race
  task automatic xfer(input logic s, input logic w, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'h00;
    @(negedge i_clock);
    o_access_valid = 1'b1;
    o_access       = '{data_sel: s, write: w, wdata: d};
    while (!i_access_ready && n < 50) begin
      @(negedge i_clock);
      n++;
    end
    @(negedge i_clock);
    o_access_valid = 1'b0;
    // Released bus shows garbage, not the old byte
    o_access       = ~o_access;
    if (!w) begin
      repeat (lag) @(negedge i_clock);
      while (!i_rd_valid && n < 50) begin
        @(negedge i_clock);
        n++;
      end
      o_rd_ready = 1'b1;
      q          = i_rd_data;
      @(negedge i_clock);
      o_rd_ready = 1'b0;
    end
    if (n >= 50) errs++;
  endtask
endmodule
`default_nettype wire

// *** lcdid_decoder_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lcdid_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module lcdid_decoder_tb;
  import lcdid_pkg::*;
  logic                     i_clock    = 1'b0;
  logic                     i_srst     = 1'b1;
  logic                     i_clock_en = 1'b1;
  logic                     acc_valid;
  lcdid_access_t            acc;
  logic                     acc_ready;
  logic                     rd_valid;
  logic                     rd_ready;
  logic [7:0]               rd_data;
  logic [`LCDID_COLS-1:0]   segs;
  logic [`LCDID_LINES-1:0]  coms;
  logic [`LCDID_LINES-1:0]  coms_q;
  logic                     at_supply;
  logic [3:0]               level;
  logic                     scan;
  logic                     pwr;
  logic                     osc;
  logic [7:0]               q;
  logic [7:0]               stop_exp [3] = '{8'h5a, 8'h00, 8'h00};
  int                       fail_count = 0;
  int                       tests_run  = 0;
  always #2.5 i_clock = ~i_clock;
  lcdid_decoder #(.INIT_CYCLES(8), .LINE_DIV(4)) dut_u (
    .i_clock(i_clock), .i_srst(i_srst), .i_clock_en(i_clock_en), .i_access_valid(acc_valid),
    .i_access(acc), .o_access_ready(acc_ready), .o_rd_valid(rd_valid), .i_rd_ready(rd_ready),
    .o_rd_data(rd_data), .o_segment_driver_outputs(segs), .o_common_outputs(coms),
    .o_outputs_at_supply(at_supply), .o_lcd_drive_level(level), .o_scan_order_bit(scan),
    .o_int_power_on(pwr), .o_osc_run(osc)
  );
  lcdid_host_model host_u (
    .i_clock(i_clock), .i_access_ready(acc_ready), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_access_valid(acc_valid), .o_access(acc), .o_rd_ready(rd_ready)
  );
  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] d);
    host_u.xfer(1'b0, 1'b1, d, q);
    repeat (3) @(negedge i_clock);
  endtask
  task automatic rd(input logic s);
    host_u.xfer(s, 1'b0, 8'h00, q);
  endtask
  task automatic col(input logic [6:0] c);
    cmd({5'h02, c[6:4]});
    cmd({4'h0, c[3:0]});
  endtask
  // Polls status until the busy flag drops
  task automatic idle();
    rd(1'b0);
    for (int n = 0; n < 30 && q[7] !== 1'b0; n++) rd(1'b0);
  endtask
  initial begin
    #20000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (2) @(negedge i_clock);
    i_srst = 1'b0;
    rd(1'b0);
    `CHK(q, 8'hf0)
    idle();
    `CHK(q, 8'h60)
    `CHK(at_supply, 1'b1)
    cmd(8'hed);
    `CHK(at_supply, 1'b0)
    cmd(8'haf);
    rd(1'b0);
    `CHK(q, 8'h40)
    cmd(8'ha1);
    rd(1'b0);
    `CHK(q, 8'h00)
    cmd(8'ha0);
    cmd(8'hb3);
    col(7'h12);
    for (int i = 0; i < 4; i++) host_u.xfer(1'b1, 1'b1, 8'(8'h30 + i), q);
    cmd(8'h02);
    cmd(8'h11);
    rd(1'b1);
    for (int i = 0; i < 4; i++) begin
      host_u.lag = i;
      rd(1'b1);
      `CHK(q, 8'(8'h30 + i))
    end
    host_u.lag = 0;
    col(7'h5f);
    host_u.xfer(1'b1, 1'b1, 8'h5a, q);
    host_u.xfer(1'b1, 1'b1, 8'ha5, q);
    col(7'h5f);
    rd(1'b1);
    foreach (stop_exp[i]) begin
      rd(1'b1);
      `CHK(q, stop_exp[i])
    end
    col(7'h12);
    rd(1'b1);
    rd(1'b1);
    `CHK(q, 8'h30)
    // Column is placed before modify mode, never while inside it
    col(7'h12);
    cmd(8'he0);
    rd(1'b1);
    rd(1'b1);
    `CHK(q, 8'h30)
    rd(1'b1);
    `CHK(q, 8'h30)
    host_u.xfer(1'b1, 1'b1, 8'h77, q);
    cmd(8'hee);
    rd(1'b1);
    rd(1'b1);
    `CHK(q, 8'h77)
    rd(1'b1);
    `CHK(q, 8'h31)
    cmd(8'ha5);
    repeat (12) @(negedge i_clock);
    `CHK(segs, {`LCDID_COLS{1'b1}})
    `CHK($onehot(coms), 1'b1)
    // Line scan must stand still while the enable is low
    i_clock_en = 1'b0;
    coms_q     = coms;
    repeat (8) @(negedge i_clock);
    `CHK(coms, coms_q)
    i_clock_en = 1'b1;
    cmd(8'ha7);
    repeat (12) @(negedge i_clock);
    `CHK(segs, {`LCDID_COLS{1'b1}})
    cmd(8'ha6);
    cmd(8'ha4);
    cmd(8'h25);
    `CHK(pwr, 1'b1)
    cmd(8'hae);
    cmd(8'ha5);
    `CHK({osc, pwr, at_supply}, 3'b001)
    cmd(8'ha4);
    `CHK({osc, pwr}, 2'b11)
    cmd(8'h8f);
    `CHK(level, 4'hf)
    cmd(8'hc8);
    `CHK(scan, 1'b1)
    cmd(8'he2);
    `CHK({level, scan}, 5'h00)
    rd(1'b0);
    `CHK(q[4], 1'b1)
    idle();
    `CHK(q, 8'h60)
    `CHK(host_u.errs, 0)
    test_done();
  end
endmodule
`default_nettype wire
